// ### rtl/pcs_cfg_regs.v
`timescale 1ns/1ns
`include "pcs_cfg_map.vh"
module pcs_cfg_regs #(
    parameter EE_CLK_DIV = 8
) (
    // clock and reset
    input wire clk,
    input wire rstn,
    // configuration access
    input wire cfgRd,
    input wire cfgWr,
    input wire [7:0] cfgAddr,
    input wire [31:0] cfgWrData,
    input wire [3:0] cfgByteEn,
    output reg [31:0] cfgRdData_q,
    output reg cfgAck_q,
    // bus events from pci core, one-cycle pulses, plus the bus master level
    input wire parityErrDetected,
    input wire serrDriven,
    input wire masterAbortEnd,
    input wire targetAbortEnd,
    input wire perrDriven,
    input wire perrSeen,
    input wire busMasterActive,
    // eeprom pins
    output reg eeCs_q,
    output reg eeSk_q,
    output reg eeDi_q,
    input wire eeDo,
    // status toward pci core
    output reg parityRespEnable_q,
    output reg [1:0] devselTiming_q,
    output reg fastB2bCapable_q,
    output reg identValid_q
);
    // ==================================================================
    // identity load
    reg rstnSeen_q;
    wire loadStart;
    wire loadDone;
    wire eeCs;
    wire eeSk;
    wire eeDi;
    wire [15:0] vendorCode;
    wire [15:0] deviceCode;

    always @(posedge clk) begin
        if (!rstn) begin
            rstnSeen_q <= 1'b0;
        end else begin
            rstnSeen_q <= 1'b1;
        end
    end

    // start pulses on the first edge after every release
    assign loadStart = ~rstnSeen_q;

    pcs_ee_loader #(
        .CLK_DIV(EE_CLK_DIV),
        .ADDR_BITS(6)
    ) u_loader (
        .clk(clk),
        .rstn(rstn),
        .start(loadStart),
        .eeCs_q(eeCs),
        .eeSk_q(eeSk),
        .eeDi_q(eeDi),
        .eeDo(eeDo),
        .vendorCode_q(vendorCode),
        .deviceCode_q(deviceCode),
        .done_q(loadDone)
    );

    // ==================================================================
    // status flags
    reg perrSeenFlag_q;
    reg serrFlag_q;
    reg mabortFlag_q;
    reg tabortFlag_q;
    reg dparFlag_q;
    wire wrStat = cfgWr && (cfgAddr == `PCS_OFS_CMDSTAT);
    wire wrHi = wrStat && cfgByteEn[3];
    wire wrCmdLo = wrStat && cfgByteEn[0];
    wire [31:0] w1c = wrHi ? cfgWrData : 32'h00000000;
    wire clrPerr = w1c[`PCS_BIT_PERR_SEEN];
    wire clrSerr = w1c[`PCS_BIT_SERR_SIG];
    wire clrMabort = w1c[`PCS_BIT_MABORT];
    wire clrTabort = w1c[`PCS_BIT_TABORT];
    wire clrDpar = w1c[`PCS_BIT_DPAR_REP];
    wire dparCause = perrDriven | perrSeen;
    // all three must meet in one cycle; a perr pulse seen while not
    // master, or with response off, leaves no trace
    wire dparEvent = dparCause & busMasterActive & parityRespEnable_q;
    reg perrSeenFlag_d;
    reg serrFlag_d;
    reg mabortFlag_d;
    reg tabortFlag_d;
    reg dparFlag_d;
    reg parityRespEnable_d;

    // set wins over a clear in the same cycle, so an event that lands
    // on the clearing write is never lost
    always @* begin
        perrSeenFlag_d = parityErrDetected | (perrSeenFlag_q & ~clrPerr);
        serrFlag_d = serrDriven | (serrFlag_q & ~clrSerr);
        mabortFlag_d = masterAbortEnd | (mabortFlag_q & ~clrMabort);
        tabortFlag_d = targetAbortEnd | (tabortFlag_q & ~clrTabort);
        dparFlag_d = dparEvent | (dparFlag_q & ~clrDpar);
        parityRespEnable_d = parityRespEnable_q;
        if (wrCmdLo) begin
            parityRespEnable_d = cfgWrData[`PCS_BIT_PAR_EN];
        end
    end

    always @(posedge clk) begin
        if (!rstn) begin
            perrSeenFlag_q <= `PCS_FLAG_RST;
            serrFlag_q <= `PCS_FLAG_RST;
            mabortFlag_q <= `PCS_FLAG_RST;
            tabortFlag_q <= `PCS_FLAG_RST;
            dparFlag_q <= `PCS_FLAG_RST;
            parityRespEnable_q <= `PCS_PAR_EN_RST;
        end else begin
            perrSeenFlag_q <= perrSeenFlag_d;
            serrFlag_q <= serrFlag_d;
            mabortFlag_q <= mabortFlag_d;
            tabortFlag_q <= tabortFlag_d;
            dparFlag_q <= dparFlag_d;
            parityRespEnable_q <= parityRespEnable_d;
        end
    end

    // ==================================================================
    // read path
    reg [31:0] identWord;
    reg [31:0] statusWord;
    reg [31:0] rdMux;

    always @* begin
        identWord = 32'h00000000;
        // a half-loaded word stays hidden until both halves arrived
        if (identValid_q) begin
            identWord[31:16] = deviceCode;
            identWord[15:0] = vendorCode;
        end
    end

    // bit 6 mirrors the enable; the other command bits read zero
    always @* begin
        statusWord = 32'h00000000;
        statusWord[`PCS_BIT_PERR_SEEN] = perrSeenFlag_q;
        statusWord[`PCS_BIT_SERR_SIG] = serrFlag_q;
        statusWord[`PCS_BIT_MABORT] = mabortFlag_q;
        statusWord[`PCS_BIT_TABORT] = tabortFlag_q;
        statusWord[`PCS_DEVSEL_HI:`PCS_DEVSEL_LO] = `PCS_DEVSEL_MEDIUM;
        statusWord[`PCS_BIT_DPAR_REP] = dparFlag_q;
        statusWord[`PCS_BIT_FB2B] = `PCS_FB2B_VAL;
        statusWord[`PCS_BIT_PAR_EN] = parityRespEnable_q;
    end

    always @* begin
        rdMux = 32'h00000000;
        if (cfgAddr == `PCS_OFS_IDENT) begin
            rdMux = identWord;
        end else if (cfgAddr == `PCS_OFS_CMDSTAT) begin
            rdMux = statusWord;
        end
    end

    // idle and unmapped cycles return zero so read data can be or-ed
    always @(posedge clk) begin
        if (!rstn) begin
            cfgRdData_q <= 32'h00000000;
            cfgAck_q <= 1'b0;
        end else begin
            cfgAck_q <= cfgRd | cfgWr;
            cfgRdData_q <= cfgRd ? rdMux : 32'h00000000;
        end
    end

    // ==================================================================
    // eeprom pins and exported state
    // pins are retimed so every output leaves a flop; the loader keeps
    // data settled a whole divider period around each rising serial clock edge
    always @(posedge clk) begin
        if (!rstn) begin
            eeCs_q <= 1'b0;
            eeSk_q <= 1'b0;
            eeDi_q <= 1'b0;
        end else begin
            eeCs_q <= eeCs;
            eeSk_q <= eeSk;
            eeDi_q <= eeDi;
        end
    end

    always @(posedge clk) begin
        if (!rstn) begin
            devselTiming_q <= `PCS_DEVSEL_MEDIUM;
            fastB2bCapable_q <= `PCS_FB2B_VAL;
            identValid_q <= 1'b0;
        end else begin
            devselTiming_q <= `PCS_DEVSEL_MEDIUM;
            fastB2bCapable_q <= `PCS_FB2B_VAL;
            identValid_q <= loadDone;
        end
    end
endmodule

// ### rtl/pcs_cfg_map.vh
// Summary of operation
// - upper half of identity word holds device code loaded from serial eeprom
// - lower half of identity word holds vendor code loaded from serial eeprom
// - identity fields reload from eeprom after every reset release
// - bit 31 sets on any detected parity error, even with response disabled
// - bit 30 sets whenever the device drove system error
// - bit 29 sets when a mastered transaction ended by master abort
// - bit 28 sets when a mastered transaction ended by target abort
// - devsel timing field reads fixed 01, medium decode timing
// - bit 24 sets on perr while bus master with response enabled
// - bit 23 reads constant one, fast back-to-back accepted as target
// - bit 6 read/write parity response enable, resets to zero
`ifndef PCS_CFG_MAP_VH
`define PCS_CFG_MAP_VH

// ==================================================================
// register offsets (byte addresses)
`define PCS_OFS_IDENT 8'h00
`define PCS_OFS_CMDSTAT 8'h04

// ==================================================================
// field positions
`define PCS_BIT_PERR_SEEN 31
`define PCS_BIT_SERR_SIG 30
`define PCS_BIT_MABORT 29
`define PCS_BIT_TABORT 28
`define PCS_DEVSEL_HI 26
`define PCS_DEVSEL_LO 25
`define PCS_BIT_DPAR_REP 24
`define PCS_BIT_FB2B 23
`define PCS_BIT_PAR_EN 6

// ==================================================================
// fixed values and resets
`define PCS_DEVSEL_MEDIUM 2'h1
`define PCS_FB2B_VAL 1'h1
`define PCS_PAR_EN_RST 1'h0
`define PCS_FLAG_RST 1'h0

// ==================================================================
// eeprom loader
`define PCS_EE_READ_CMD 3'h6
`define PCS_EE_WORD_DEV 6'h01
`define PCS_EE_WORD_VEN 6'h00

`endif

// ### rtl/pcs_ee_loader.v
`timescale 1ns/1ns
`include "pcs_cfg_map.vh"
// microwire-style serial eeprom reader: fetches vendor then device word
module pcs_ee_loader #(
    parameter CLK_DIV = 8,
    parameter ADDR_BITS = 6
) (
    // clock and reset
    input wire clk,
    input wire rstn,
    // control
    input wire start,
    // eeprom pins
    output reg eeCs_q,
    output reg eeSk_q,
    output reg eeDi_q,
    input wire eeDo,
    // result
    output reg [15:0] vendorCode_q,
    output reg [15:0] deviceCode_q,
    output reg done_q
);
    localparam ST_IDLE = 2'h0;
    localparam ST_SHIFT = 2'h1;
    localparam ST_GAP = 2'h2;
    localparam ST_DONE = 2'h3;
    localparam FRAME = 3 + ADDR_BITS + 16;

    reg [1:0] state_q;
    reg [7:0] divCnt_q;
    reg [5:0] bitCnt_q;
    reg wordSel_q;
    reg [FRAME-1:0] outShift_q;
    reg [15:0] inShift_q;
    reg doMeta_q;
    reg doSync_q;

    wire [ADDR_BITS-1:0] wordAddr = wordSel_q ?
        `PCS_EE_WORD_DEV : `PCS_EE_WORD_VEN;
    wire [FRAME-1:0] frameWord = {`PCS_EE_READ_CMD, wordAddr, 16'h0000};
    wire tick = (divCnt_q == CLK_DIV[7:0] - 8'h01);

    // eeprom data out is asynchronous to clk
    always @(posedge clk) begin
        doMeta_q <= eeDo;
        doSync_q <= doMeta_q;
    end

    always @(posedge clk) begin
        if (!rstn) begin
            state_q <= ST_IDLE;
            divCnt_q <= 8'h00;
            bitCnt_q <= 6'h00;
            wordSel_q <= 1'b0;
            outShift_q <= {FRAME{1'b0}};
            inShift_q <= 16'h0000;
            eeCs_q <= 1'b0;
            eeSk_q <= 1'b0;
            eeDi_q <= 1'b0;
            vendorCode_q <= 16'h0000;
            deviceCode_q <= 16'h0000;
            done_q <= 1'b0;
        end else begin
            divCnt_q <= tick ? 8'h00 : divCnt_q + 8'h01;
            case (state_q)
                ST_IDLE: begin
                    if (start) begin
                        state_q <= ST_GAP;
                        wordSel_q <= 1'b0;
                        done_q <= 1'b0;
                    end
                end
                ST_GAP: begin
                    eeCs_q <= 1'b0;
                    if (tick) begin
                        // first bit leaves with select, half a period
                        // ahead of the first rising serial clock
                        eeCs_q <= 1'b1;
                        eeDi_q <= frameWord[FRAME-1];
                        outShift_q <= {frameWord[FRAME-2:0], 1'b0};
                        bitCnt_q <= FRAME[5:0];
                        state_q <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (tick) begin
                        eeSk_q <= ~eeSk_q;
                        // falling edge: sample data out, then move data
                        // in while the clock is low, so it is settled
                        // long before the eeprom samples it on the rise
                        if (eeSk_q) begin
                            inShift_q <= {inShift_q[14:0], doSync_q};
                            eeDi_q <= outShift_q[FRAME-1];
                            outShift_q <= {outShift_q[FRAME-2:0], 1'b0};
                            bitCnt_q <= bitCnt_q - 6'h01;
                            if (bitCnt_q == 6'h01) begin
                                eeCs_q <= 1'b0;
                                if (wordSel_q) begin
                                    deviceCode_q <= {inShift_q[14:0],
                                        doSync_q};
                                    state_q <= ST_DONE;
                                end else begin
                                    vendorCode_q <= {inShift_q[14:0],
                                        doSync_q};
                                    wordSel_q <= 1'b1;
                                    state_q <= ST_GAP;
                                end
                            end
                        end
                    end
                end
                default: begin
                    done_q <= 1'b1;
                    eeSk_q <= 1'b0;
                    eeDi_q <= 1'b0;
                end
            endcase
        end
    end
endmodule

// ### sim/pcs_cfg_regs_sva.sv
`timescale 1ns/1ns
module pcs_cfg_regs_sva (
    // clock, reset, access
    input wire clk,
    input wire rstn,
    input wire cfgRd,
    input wire cfgWr,
    input wire [7:0] cfgAddr,
    input wire [31:0] cfgWrData,
    input wire [3:0] cfgByteEn,
    input wire [31:0] cfgRdData_q,
    // events and status
    input wire parityErrDetected,
    input wire parityRespEnable_q,
    input wire [1:0] devselTiming_q,
    input wire fastB2bCapable_q,
    input wire identValid_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // ==========================================
    // status read and identity read
    sequence s_rdSt;
        cfgRd && cfgAddr == 8'h04;
    endsequence
    sequence s_rdId;
        cfgRd && cfgAddr == 8'h00;
    endsequence
    property p_dsel; devselTiming_q == 2'h1; endproperty
    a_dsel: assert property (p_dsel) else $error("devsel bad");
    property p_fbb; fastB2bCapable_q; endproperty
    a_fbb: assert property (p_fbb) else $error("fb2b low");
    property p_enWr; cfgWr && cfgAddr == 8'h04 && cfgByteEn[0]
        |=> parityRespEnable_q == $past(cfgWrData[6]); endproperty
    a_enWr: assert property (p_enWr) else $error("enable write");
    property p_enHold; !(cfgWr && cfgAddr == 8'h04 && cfgByteEn[0])
        |=> $stable(parityRespEnable_q); endproperty
    a_enHold: assert property (p_enHold) else $error("enable moved");
    property p_perr; parityErrDetected ##1 s_rdSt |=> cfgRdData_q[31];
    endproperty
    a_perr: assert property (p_perr) else $error("parity flag");
    property p_resv; s_rdSt |=> (cfgRdData_q & 32'h0860ffbf) == 32'h0;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved set");
    property p_unmap; cfgRd && cfgAddr != 8'h00 && cfgAddr != 8'h04
        |=> cfgRdData_q == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped data");
    property p_early; s_rdId ##1 !identValid_q |-> cfgRdData_q == 32'h0;
    endproperty
    a_early: assert property (p_early) else $error("early ident");
    property p_reld; $rose(rstn) |-> !identValid_q [*8]; endproperty
    a_reld: assert property (p_reld) else $error("no reload");
endmodule

bind pcs_cfg_regs pcs_cfg_regs_sva u_sva (
    .clk(clk), .rstn(rstn), .cfgRd(cfgRd), .cfgWr(cfgWr),
    .cfgAddr(cfgAddr), .cfgWrData(cfgWrData), .cfgByteEn(cfgByteEn),
    .cfgRdData_q(cfgRdData_q), .parityErrDetected(parityErrDetected),
    .parityRespEnable_q(parityRespEnable_q),
    .devselTiming_q(devselTiming_q), .fastB2bCapable_q(fastB2bCapable_q),
    .identValid_q(identValid_q)
);

// ### sim/pcs_ee_model.sv
`timescale 1ns/1ns
// serial eeprom stand-in, read command only
module pcs_ee_model #(
    parameter [15:0] VENDOR = 16'h5a3c, // arbitrary value
    parameter [15:0] DEVICE = 16'hc3a5 // arbitrary value
) (
    // eeprom pins
    input wire eeCs,
    input wire eeSk,
    input wire eeDi,
    output reg eeDo
);
    integer bitCnt = 0;
    reg [5:0] addr = 6'h0;
    wire [15:0] word = (addr == 6'h00) ? VENDOR : DEVICE;
    initial eeDo = 1'b0;
    // deselected output floats: show the inverse, never a stale bit
    always @(negedge eeCs) begin
        bitCnt <= 0;
        eeDo <= ~eeDo;
    end
    always @(posedge eeSk) begin
        if (eeCs) begin
            bitCnt <= bitCnt + 1;
            if (bitCnt >= 3 && bitCnt < 9)
                addr <= {addr[4:0], eeDi};
            if (bitCnt >= 9 && bitCnt < 25)
                eeDo <= word[24 - bitCnt];
        end
    end
endmodule

// ### sim/tb_pci_cfg_ident_status.sv
`timescale 1ns/1ns
module tb_pci_cfg_ident_status;
    localparam [15:0] VEN = 16'h5a3c;
    localparam [15:0] DEV = 16'hc3a5;
    reg clk, rstn, cfgRd, cfgWr, busMaster, perrDrv, perrSeen;
    reg [7:0] addr, flg;
    reg [31:0] wdata, rdata;
    reg [3:0] be, ev;
    wire [31:0] rdq;
    wire [1:0] dsel;
    wire ack, eeCs, eeSk, eeDi, eeDo, penQ, fbb, identValid;
    integer nFail = 0, compares = 0, i, pass;
    pcs_cfg_regs #(.EE_CLK_DIV(4)) DUT (
        .clk(clk), .rstn(rstn), .cfgRd(cfgRd), .cfgWr(cfgWr),
        .cfgAddr(addr), .cfgWrData(wdata), .cfgByteEn(be),
        .cfgRdData_q(rdq), .cfgAck_q(ack),
        .parityErrDetected(ev[3]), .serrDriven(ev[2]),
        .masterAbortEnd(ev[1]), .targetAbortEnd(ev[0]),
        .perrDriven(perrDrv), .perrSeen(perrSeen),
        .busMasterActive(busMaster),
        .eeCs_q(eeCs), .eeSk_q(eeSk), .eeDi_q(eeDi), .eeDo(eeDo),
        .parityRespEnable_q(penQ), .devselTiming_q(dsel),
        .fastB2bCapable_q(fbb), .identValid_q(identValid)
    );
    pcs_ee_model #(.VENDOR(VEN), .DEVICE(DEV)) eeprom (
        .eeCs(eeCs), .eeSk(eeSk), .eeDi(eeDi), .eeDo(eeDo)
    );
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // ==========================================
    // helpers, all entered at a falling edge
    function [31:0] stat(input [7:0] f, input p);
        stat = 32'h02800000 | {f, 24'h0} | {25'h0, p, 6'h0};
    endfunction
    task check(input [31:0] exp, input [31:0] got, input string what);
        compares = compares + 1;
        if (got !== exp) begin
            nFail = nFail + 1;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task acc(input wr, input [7:0] a, input [31:0] d, input [3:0] b);
        cfgRd = !wr;
        cfgWr = wr;
        addr = a;
        wdata = d;
        be = b;
        @(negedge clk);
        cfgRd = 1'b0;
        cfgWr = 1'b0;
        rdata = rdq;
        check(32'h1, {31'h0, ack}, "ack");
        @(negedge clk);
    endtask
    task pulse(input [3:0] e, input d, input s);
        ev = e;
        perrDrv = d;
        perrSeen = s;
        @(negedge clk);
        ev = 4'h0;
        perrDrv = 1'b0;
        perrSeen = 1'b0;
    endtask
    task conclude;
        $display("compares %0d mismatches %0d", compares, nFail);
        if (nFail == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // ==========================================
    // main sequence
    initial begin
        i = $urandom(32'hcced3ca7);
        {rstn, cfgRd, cfgWr, busMaster, perrDrv, perrSeen} = 6'h0;
        {addr, flg, wdata, be, ev} = 0;
        repeat (6) @(negedge clk);
        for (pass = 0; pass < 2; pass++) begin
            rstn = 1'b1;
            acc(0, 8'h00, 32'h0, 4'hf);
            check(32'h0, rdata, "ident early");
            for (i = 0; i < 3000 && identValid !== 1'b1; i++)
                @(negedge clk);
            acc(1, 8'h00, $urandom, 4'hf);
            acc(0, 8'h00, 32'h0, 4'hf);
            check({DEV, VEN}, rdata, "ident");
            acc(0, 8'h04, 32'h0, 4'hf);
            check(stat(8'h0, 1'b0), rdata, "status");
            acc(0, 8'h08 + (($urandom % 62) << 2), 32'h0, 4'hf);
            check(32'h0, rdata, "unmapped");
            if (pass == 0) begin
                for (i = 0; i < 4; i++) begin
                    pulse(4'h8 >> i, 1'b0, 1'b0);
                    flg = 8'h80 >> i;
                    acc(0, 8'h04, 32'h0, 4'hf);
                    check(stat(flg, 1'b0), rdata, "flag set");
                    acc(1, 8'h04, $urandom & ~{flg, 24'h0}, 4'h8);
                    acc(0, 8'h04, 32'h0, 4'hf);
                    check(stat(flg, 1'b0), rdata, "write zero");
                    acc(1, 8'h04, $urandom | {flg, 24'h0}, 4'h8);
                    acc(0, 8'h04, 32'h0, 4'hf);
                    check(stat(8'h0, 1'b0), rdata, "flag clear");
                end
                for (i = 0; i < 16; i++) begin
                    acc(1, 8'h04, {25'h0, i[3], 6'h0}, 4'h1);
                    check({31'h0, i[3]}, {31'h0, penQ}, "enable");
                    busMaster = i[2];
                    pulse(4'h0, i[0], i[1]);
                    flg = {7'h0, (i[0] | i[1]) & i[2] & i[3]};
                    acc(0, 8'h04, 32'h0, 4'hf);
                    check(stat(flg, i[3]), rdata, "parity report");
                    acc(1, 8'h04, 32'h01000000, 4'h8);
                end
                rstn = 1'b0;
                repeat (2) @(negedge clk);
            end
        end
        conclude;
    end
    initial begin
        #200000;
        nFail = nFail + 1;
        conclude;
    end
endmodule
